// ===== sfc_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_fifo2 #(
  parameter int W     = 33,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  // shift-register queue: head is always slot 0, so outputs come from flops
  logic [DEPTH-1:0] valid_q;
  logic [W-1:0]     data_q [DEPTH];
  logic [DEPTH-1:0] sv;
  logic [W-1:0]     sd [DEPTH];
  logic             pop;
  logic             push;

  assign pop         = valid_q[0] & out_ready_i;
  assign in_ready_o  = ~valid_q[DEPTH-1];
  assign push        = in_valid_i & in_ready_o;
  assign out_valid_o = valid_q[0];
  assign out_data_o  = data_q[0];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        sv[i] = (i < DEPTH-1) ? valid_q[(i+1)%DEPTH] : 1'b0;
        sd[i] = data_q[(i+1)%DEPTH];
      end else begin
        sv[i] = valid_q[i];
        sd[i] = data_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      valid_q <= '0;
      for (int i = 0; i < DEPTH; i++) data_q[i] <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && !sv[i] && (i == 0 || sv[(i+DEPTH-1)%DEPTH])) begin
          valid_q[i] <= 1'b1;
          data_q[i]  <= in_data_i;
        end else begin
          valid_q[i] <= sv[i];
          data_q[i]  <= sd[i];
        end
      end
    end
  end
endmodule // sfc_fifo2
`default_nettype wire

// ===== sfc_mod_src.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_mod_src (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic slow_i,
  input  wire logic pol_i,
  output logic      tick_o,
  output logic      bit_o
);
  // pattern period of 4 divides 1024, so every base period sums alike
  logic [1:0] ph_q;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tick_o <= 1'b0;
      ph_q   <= 2'h0;
    end else begin
      tick_o <= slow_i ? !tick_o : 1'b1;
      if (tick_o) ph_q <= ph_q + 2'h1;
    end
  end
  // swapped input pair inverts the stream
  assign bit_o = (ph_q != 2'h3) ^ pol_i;
endmodule // sfc_mod_src
`default_nettype wire

// ===== sfc_pkg.sv
`default_nettype none
package sfc_pkg;

  // divider word and decimation base
  localparam int FS_W     = 10;
  localparam int DEC_LOG2 = 10;                  // 1024 master ticks per divider unit
  localparam int SUB_W    = 24;                  // one base-period partial sum
  localparam int WIN_W    = SUB_W + 2;           // up to four partial sums
  localparam int DATA_W   = 32;
  localparam int ADR_W    = 8;

  // nominal converter master clock, for reference only
  localparam int FCLK_NOM_HZ = 4920000;
  // host clock of this block: 250 MHz
  localparam int MCLK_PERIOD_NS = 4;

  localparam logic [2:0]       ORDER_FILTER_ORDER_SELECT = 3'h3;
  localparam logic [2:0]       ORDER_SINC4 = 3'h4;
  localparam logic [FS_W-1:0]  FS_MIN      = 10'h001;
  localparam logic [FS_W-1:0]  FS_RESET    = 10'h060;

  // register byte offsets
  localparam logic [ADR_W-1:0] ADR_MODE = 8'h00;
  localparam logic [ADR_W-1:0] ADR_STAT = 8'h04;
  localparam logic [ADR_W-1:0] ADR_DATA = 8'h08;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h0c;

  // mode register fields
  localparam int MODE_FS_LSB    = 0;
  localparam int MODE_ZL_BIT    = 11;
  localparam int MODE_NOTCH_BIT = 13;
  localparam int MODE_ORDER_BIT = 15;
  localparam int MODE_CHOP_BIT  = 23;

  // status and control fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_OVR_BIT   = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_POL_BIT   = 4;
  localparam int CTRL_RESTART   = 0;

  typedef struct packed {
    logic            chop;
    logic            order3;
    logic            notch;
    logic            zero_lat;
    logic [FS_W-1:0] fs;
  } sfc_mode_t;

  localparam sfc_mode_t MODE_RESET = '{chop: 1'b0, order3: 1'b0, notch: 1'b0, zero_lat: 1'b0, fs: FS_RESET};

  typedef struct packed {
    logic              chop;
    logic [DATA_W-1:0] value;
  } sfc_result_t;

  typedef enum logic [1:0] {
    SFC_IDLE   = 2'b00,
    SFC_SETTLE = 2'b01,
    SFC_RUN    = 2'b11
  } sfc_state_t;

endpackage
`default_nettype wire

// ===== sfc_rate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_rate_timer #(
  parameter int FS_W  = 10,
  parameter int DEC_W = 10
) (
  input  wire logic            clk_i,
  input  wire logic            reset_n_i,
  input  wire logic            restart_i,
  input  wire logic            tick_i,
  input  wire logic [FS_W-1:0] fs_i,
  output logic                 period_end_o
);
  // one base period is fs * 2**DEC_W master ticks
  logic [FS_W+DEC_W-1:0] cnt_q;
  logic [FS_W+DEC_W-1:0] last;
  logic                  at_last;

  assign last         = {fs_i, {DEC_W{1'b0}}} - {{(FS_W+DEC_W-1){1'b0}}, 1'b1};
  assign at_last      = (cnt_q == last);
  assign period_end_o = tick_i & at_last & ~restart_i;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || restart_i) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= at_last ? '0 : cnt_q + {{(FS_W+DEC_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sfc_rate_timer
`default_nettype wire

// ===== sfc_top.sv
// Operation
// - filter_order_select, chop off, word 96: 50 Hz results, 16.7 Hz with zero latency
// - filter_order_select, chop off, word 80: 60 Hz results, 20 Hz with zero latency
// - filter_order_select, chop off, word 480: 10 Hz results, 3.3 Hz with zero latency
// - filter_order_select, word 96 with extra notch: notches at 50 and 60 Hz
// - chop: convert, swap input polarity, convert again, average successive conversions
// - sinc4 chop rate is master clock over 4 x 1024 x divider word
// - filter_order_select chop rate is master clock over 3 x 1024 x divider word
// - chop divider word ranges 1 to 1023
// - chop settling time is two output periods for either order
// - channel change resets filter; first result after full settling, then every period
// - after input step keep converting; accurate two or three conversions later
// - chopping adds notches at odd multiples of half output rate
// - chop with word 96: extra notch leaves output rate unchanged
// - order select 1 picks the third-order filter
// - mode bit 11 enables zero latency, full settling per conversion
`timescale 1ns/1ps
`default_nettype none
module sfc_top
  import sfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_n_i,
  // modulator side
  input  wire logic               mod_tick_i,
  input  wire logic               mod_bit_i,
  input  wire logic               chan_change_i,
  output logic                    chop_polarity_o,
  output logic                    filter_reset_o,
  // result stream
  output logic                    res_valid_o,
  input  wire logic               res_ready_i,
  output sfc_result_t             res_data_o,
  // classic wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [DATA_W-1:0]  wb_dat_i,
  output logic [DATA_W-1:0]       wb_dat_o,
  output logic                    wb_ack_o
);

  localparam logic signed [SUB_W-1:0] SUB_ONE = 24'sh000001;

  sfc_mode_t             mode_q;
  sfc_mode_t             cfg_q;
  sfc_state_t            state_q;
  logic                  restart_q;
  logic                  restart_req;
  logic                  ack_q;
  logic [DATA_W-1:0]     rdat_q;
  logic                  req;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  period_end;
  logic signed [SUB_W-1:0] acc_q;
  logic signed [SUB_W-1:0] hist_q [3];
  logic signed [SUB_W-1:0] step;
  logic signed [SUB_W-1:0] cur_sub;
  logic signed [WIN_W-1:0] win_sum;
  logic signed [WIN_W-1:0] conv_prev_q;
  logic signed [WIN_W:0]   chop_sum;
  logic signed [WIN_W-1:0] raw;
  logic signed [WIN_W:0]   notch_sum;
  logic signed [WIN_W-1:0] final_val;
  logic signed [WIN_W-1:0] last_out_q;
  logic                  conv_have_q;
  logic                  out_have_q;
  logic [1:0]            phase_q;
  logic [2:0]            nper_q;
  logic [2:0]            order_n;
  logic                  last_phase;
  logic                  emit;
  logic                  pol_q;
  logic                  ready_q;
  logic                  ovr_q;
  logic                  pend_q;
  sfc_result_t           pend_data_q;
  logic                  fifo_in_ready;
  logic [FS_W-1:0]       fs_eff;

  // ---------------------------------------------------------------- bus
  assign req     = wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wr_fire = req & wb_we_i & ack_q;
  assign rd_fire = req & ~wb_we_i & ack_q;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdat_q <= '0;
    end else if (req && !ack_q) begin
      unique case (wb_adr_i)
        ADR_MODE: rdat_q <= DATA_W'({mode_q.chop, 7'h00, mode_q.order3, 1'b0, mode_q.notch, 1'b0,
                                     mode_q.zero_lat, 1'b0, mode_q.fs});
        ADR_STAT: rdat_q <= DATA_W'({pol_q, state_q, ovr_q, ready_q});
        ADR_DATA: rdat_q <= pend_data_q.value;
        default:  rdat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // mode register, byte lanes honoured
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      mode_q <= MODE_RESET;
    end else if (wr_fire && wb_adr_i == ADR_MODE) begin
      if (wb_sel_i[0]) mode_q.fs[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        mode_q.fs[FS_W-1:8] <= wb_dat_i[FS_W-1:8];
        mode_q.zero_lat     <= wb_dat_i[MODE_ZL_BIT];
        mode_q.notch        <= wb_dat_i[MODE_NOTCH_BIT];
        mode_q.order3       <= wb_dat_i[MODE_ORDER_BIT];
      end
      if (wb_sel_i[2]) mode_q.chop <= wb_dat_i[MODE_CHOP_BIT];
    end
  end

  // a new mode, a channel change or a software restart opens a new sequence
  assign restart_req = chan_change_i
                     | (wr_fire && wb_adr_i == ADR_MODE)
                     | (wr_fire && wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RESTART]);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      restart_q <= 1'b1;
    end else begin
      restart_q <= restart_req;
    end
  end

  assign filter_reset_o = restart_q;

  // configuration is only taken when a sequence starts
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cfg_q <= MODE_RESET;
    end else if (restart_q) begin
      cfg_q <= mode_q;
    end
  end

  // ---------------------------------------------------------------- timing
  // word 0 is out of range; run it as word 1, the fastest legal rate
  assign fs_eff  = (cfg_q.fs < FS_MIN) ? FS_MIN : cfg_q.fs;
  assign order_n = cfg_q.order3 ? ORDER_FILTER_ORDER_SELECT : ORDER_SINC4;

  sfc_rate_timer #(
    .FS_W  (FS_W),
    .DEC_W (DEC_LOG2)
  ) u_timer (
    .clk_i        (mclk_i),
    .reset_n_i    (reset_n_i),
    .restart_i    (restart_q),
    .tick_i       (mod_tick_i),
    .fs_i         (fs_eff),
    .period_end_o (period_end)
  );

  // ---------------------------------------------------------------- datapath
  // undo the input swap so both polarities add the same sign
  always_comb begin
    if (!mod_tick_i || restart_q) begin
      step = '0;
    end else if (mod_bit_i ^ pol_q) begin
      step = SUB_ONE;
    end else begin
      step = -SUB_ONE;
    end
  end

  assign cur_sub    = acc_q + step;
  assign last_phase = ({1'b0, phase_q} == order_n - 3'h1);

  // window is the newest order_n base periods
  assign win_sum = WIN_W'(cur_sub) + WIN_W'(hist_q[0]) + WIN_W'(hist_q[1])
                 + (cfg_q.order3 ? '0 : WIN_W'(hist_q[2]));

  // chop result averages this conversion with the opposite-polarity one
  assign chop_sum = (WIN_W+1)'(win_sum) + (WIN_W+1)'(conv_prev_q);

  always_comb begin
    emit = 1'b0;
    raw  = win_sum;
    if (period_end) begin
      if (cfg_q.chop) begin
        emit = last_phase && conv_have_q;
        raw  = WIN_W'(chop_sum >>> 1);
      end else if (cfg_q.zero_lat) begin
        emit = last_phase;
      end else begin
        emit = (nper_q >= order_n - 3'h1);
      end
    end
  end

  // extra notch: comb with the previous result, rate untouched
  assign notch_sum = (WIN_W+1)'(raw) + (WIN_W+1)'(last_out_q);
  assign final_val = (cfg_q.notch && out_have_q) ? WIN_W'(notch_sum >>> 1) : raw;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart_q) begin
      acc_q <= '0;
      for (int i = 0; i < 3; i++) hist_q[i] <= '0;
    end else if (period_end) begin
      acc_q     <= '0;
      hist_q[0] <= cur_sub;
      hist_q[1] <= hist_q[0];
      hist_q[2] <= hist_q[1];
    end else begin
      acc_q <= cur_sub;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart_q) begin
      phase_q <= '0;
      nper_q  <= '0;
    end else if (period_end) begin
      phase_q <= last_phase ? 2'h0 : phase_q + 2'h1;
      if (nper_q < order_n) nper_q <= nper_q + 3'h1;
    end
  end

  // with chop on, polarity swaps after each settled conversion
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart_q) begin
      pol_q       <= 1'b0;
      conv_have_q <= 1'b0;
      conv_prev_q <= '0;
    end else if (period_end && cfg_q.chop && last_phase) begin
      pol_q       <= ~pol_q;
      conv_have_q <= 1'b1;
      conv_prev_q <= win_sum;
    end
  end

  assign chop_polarity_o = pol_q;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart_q) begin
      out_have_q <= 1'b0;
      last_out_q <= '0;
    end else if (emit) begin
      out_have_q <= 1'b1;
      last_out_q <= raw;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart_q) begin
      state_q <= SFC_IDLE;
    end else begin
      unique case (state_q)
        SFC_IDLE:   if (mod_tick_i) state_q <= SFC_SETTLE;
        SFC_SETTLE: if (emit) state_q <= SFC_RUN;
        SFC_RUN:    state_q <= SFC_RUN;
        default:    state_q <= SFC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------- output
  // one result waits here while the buffer is full; a second one overwrites it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else begin
      if (emit) begin
        pend_q      <= 1'b1;
        pend_data_q <= '{chop: cfg_q.chop, value: DATA_W'(final_val)};
      end else if (fifo_in_ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ready_q <= 1'b0;
      ovr_q   <= 1'b0;
    end else begin
      // set wins over a clear in the same cycle
      if (emit) begin
        ready_q <= 1'b1;
      end else if (rd_fire && wb_adr_i == ADR_DATA) begin
        ready_q <= 1'b0;
      end
      if (emit && pend_q && !fifo_in_ready) begin
        ovr_q <= 1'b1;
      end else if (wr_fire && wb_adr_i == ADR_STAT && wb_sel_i[0] && wb_dat_i[STAT_OVR_BIT]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  sfc_fifo2 #(
    .W     ($bits(sfc_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .clk_i       (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (pend_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_data_q),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );

endmodule // sfc_top
`default_nettype wire

// ===== sfc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_top_props
  import sfc_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  input wire logic              mod_tick_i,
  input wire logic              mod_bit_i,
  input wire logic              chan_change_i,
  input wire logic              chop_polarity_o,
  input wire logic              filter_reset_o,
  input wire logic              res_valid_o,
  input wire logic              res_ready_i,
  input wire sfc_result_t       res_data_o,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADR_W-1:0]  wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o
);
  // no result can appear sooner than one base period after a restart
  logic [15:0] quiet_q;
  wire         req = wb_cyc_i && wb_stb_i;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || filter_reset_o) quiet_q <= 16'h0000;
    else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h0001;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ack_next; req && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; !req |=> !wb_ack_o; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold; !req && !wb_ack_o |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_restart; chan_change_i |=> filter_reset_o; endproperty
  a_restart: assert property (p_restart) else $error("no restart on channel change");
  property p_wake; $rose(reset_n_i) |-> !wb_ack_o && !res_valid_o && !chop_polarity_o; endproperty
  a_wake: assert property (p_wake) else $error("outputs not cleared by reset");
  property p_hold;
    res_valid_o && !res_ready_i && !filter_reset_o && !chan_change_i |=> res_valid_o && $stable(res_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled result lost");
  // a result already in flight when the restart lands surfaces with the count still at zero
  property p_quiet; $rose(res_valid_o) && quiet_q != 16'h0000 |-> quiet_q >= 16'h0400; endproperty
  a_quiet: assert property (p_quiet) else $error("result before settling");
endmodule // sfc_top_props

bind sfc_top sfc_top_props u_sfc_top_props (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mod_tick_i(mod_tick_i), .mod_bit_i(mod_bit_i),
  .chan_change_i(chan_change_i), .chop_polarity_o(chop_polarity_o), .filter_reset_o(filter_reset_o),
  .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_data_o(res_data_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// ===== sfc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module sfc_top_tb
  import sfc_pkg::*;
;
  logic              mclk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              slow = 1'b0;
  logic              tick;
  logic              bitv;
  logic              chan_change_i = 1'b0;
  logic              res_ready_i = 1'b1;
  logic              chop_polarity_o;
  logic              res_valid_o;
  sfc_result_t       res_data_o;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [DATA_W-1:0] wb_dat_i = 32'h00000000;
  logic [DATA_W-1:0] wb_dat_o;
  logic              wb_ack_o;
  logic [DATA_W-1:0] rd;
  int                bad_count = 0;
  int                comparisons = 0;
  int                cyc_n = 0;
  int                pop_t[$];
  logic              pop_p[$];
  logic [DATA_W-1:0] pop_v[$];
  logic              pop_c[$];

  sfc_top u_sfc_top (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mod_tick_i(tick), .mod_bit_i(bitv),
    .chan_change_i(chan_change_i), .chop_polarity_o(chop_polarity_o), .filter_reset_o(),
    .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_data_o(res_data_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );
  sfc_mod_src u_sfc_mod_src (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_i(slow), .pol_i(chop_polarity_o),
    .tick_o(tick), .bit_o(bitv)
  );

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cyc_n <= cyc_n + 1;
    if (res_valid_o && res_ready_i) begin
      pop_t.push_back(cyc_n);
      pop_p.push_back(chop_polarity_o);
      pop_v.push_back(res_data_o.value);
      pop_c.push_back(res_data_o.chop);
    end
    if (cyc_n > 99000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // skips anything still in flight from the old mode before counting
  task automatic run_mode(input logic [31:0] m, input int first, input int per, input logic chop);
    int t0;
    int k;
    wb_xfer(1'b1, ADR_MODE, m);
    repeat (4) @(posedge mclk_i);
    k = pop_t.size();
    t0 = cyc_n - 4;
    while (pop_t.size() < k + 3) @(posedge mclk_i);
    `CHK("first", 1'b1, (pop_t[k] - t0 >= first - 2) && (pop_t[k] - t0 <= first + 8))
    `CHK("period", per, pop_t[k+2] - pop_t[k+1])
    `CHK("steady", pop_v[k+1], pop_v[k+2])
    // partner pattern nets 512 per 1024 ticks for every unit of the divider word
    `CHK("value", 32'(512 * m[FS_W-1:0] * (m[MODE_ORDER_BIT] ? ORDER_FILTER_ORDER_SELECT : ORDER_SINC4)), pop_v[k+1])
    `CHK("chop_bit", chop, pop_c[k+1])
    if (chop) `CHK("polarity", !pop_p[k+1], pop_p[k+2])
  endtask

  task automatic t_regs();
    wb_xfer(1'b0, ADR_MODE, 32'h0);
    `CHK("mode_rst", 32'h00000060, rd)
    wb_xfer(1'b1, 8'h10, 32'hffffffff);
    wb_xfer(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h00000000, rd)
  endtask

  task automatic t_filter_order_select();
    run_mode(32'h00008002, 6144, 2048, 1'b0);
    run_mode(32'h00008801, 3072, 3072, 1'b0);
    run_mode(32'h0000a001, 3072, 1024, 1'b0);
    slow <= 1'b1;
    run_mode(32'h00008001, 6144, 2048, 1'b0);
    slow <= 1'b0;
  endtask

  task automatic t_chop();
    run_mode(32'h00808001, 6144, 3072, 1'b1);
    run_mode(32'h00800001, 8192, 4096, 1'b1);
    run_mode(32'h0080a001, 6144, 3072, 1'b1);
  endtask

  task automatic t_chan();
    int t0;
    int k;
    chan_change_i <= 1'b1;
    @(posedge mclk_i);
    chan_change_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    k = pop_t.size();
    t0 = cyc_n - 5;
    while (pop_t.size() < k + 2) @(posedge mclk_i);
    `CHK("chan_first", 1'b1, (pop_t[k] - t0 >= 6144) && (pop_t[k] - t0 <= 6154))
    `CHK("chan_next", 3072, pop_t[k+1] - pop_t[k])
    `CHK("chan_val", pop_v[k], pop_v[k+1])
  endtask

  task automatic t_stall();
    res_ready_i <= 1'b0;
    wb_xfer(1'b1, ADR_MODE, 32'h00008001);
    repeat (3072 + 4 * 1024 + 20) @(posedge mclk_i);
    `CHK("stall_valid", 1'b1, res_valid_o)
    wb_xfer(1'b0, ADR_STAT, 32'h0);
    `CHK("ovr_set", 1'b1, rd[STAT_OVR_BIT])
    `CHK("ready_set", 1'b1, rd[STAT_READY_BIT])
    `CHK("state_run", SFC_RUN, rd[STAT_STATE_LSB+:2])
    wb_xfer(1'b0, ADR_DATA, 32'h0);
    `CHK("data_reg", 32'(512 * ORDER_FILTER_ORDER_SELECT), rd)
    wb_xfer(1'b0, ADR_STAT, 32'h0);
    `CHK("ready_clr", 1'b0, rd[STAT_READY_BIT])
    res_ready_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    `CHK("drained", 1'b0, res_valid_o)
    wb_xfer(1'b1, ADR_STAT, 32'h00000002);
    wb_xfer(1'b0, ADR_STAT, 32'h0);
    `CHK("ovr_clr", 1'b0, rd[STAT_OVR_BIT])
    wb_xfer(1'b1, ADR_CTRL, 32'h00000001);
    wb_xfer(1'b0, ADR_STAT, 32'h0);
    `CHK("restart", 1'b1, rd[STAT_STATE_LSB+:2] != SFC_RUN)
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_filter_order_select();
    t_chop();
    t_chan();
    t_stall();
    final_report();
  end
endmodule // sfc_top_tb
`default_nettype wire
